/* tcc_params.svh */
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// Register word offsets on the plain register port.
`define TCC_OFS_CSC 2'h0
`define TCC_OFS_EVT 2'h1
`define TCC_OFS_MASK 2'h2

// Field positions of channel_status_control.
`define TCC_BIT_FLAG 7
`define TCC_BIT_IE 6
`define TCC_BIT_MS_HI 5
`define TCC_BIT_MS_LO 4
`define TCC_ELS_HI 3
`define TCC_ELS_LO 2

// Field positions of the event status and mask registers.
`define TCC_EVT_SET 0
`define TCC_EVT_OVR 1
`define TCC_EVT_W 2

// Reset values.
`define TCC_RST_BYTE 8'h00
`define TCC_RST_EVT 2'h0

// Edge/level select codes.
`define TCC_ELS_OFF 2'h0
`define TCC_ELS_01 2'h1
`define TCC_ELS_10 2'h2
`define TCC_ELS_11 2'h3

`endif

/* tcc_pkg.sv */
`default_nettype none
package tcc_pkg;

    typedef enum logic [1:0] {
        TCC_MODE_CAPTURE,
        TCC_MODE_COMPARE,
        TCC_MODE_EPWM,
        TCC_MODE_CPWM
    } tcc_mode_e;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcc_bus_s;

    typedef struct packed {
        logic cnt_match;
        logic cnt_ovf;
        logic count_up;
        logic duty_extreme;
        logic center_pwm_select;
    } tcc_tmr_s;

endpackage
`default_nettype wire

/* tcc_channel.sv */
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"
// Contract
// - Input capture sets the event flag on the selected pin edge.
// - Compare and PWM modes set the event flag on a counter match.
// - PWM at zero or full duty never sets the event flag.
// - Channel interrupt requested while flag set and interrupt enable is one.
// - Flag clears only after read-while-set then write of zero.
// - A new event restarts the clear sequence and keeps the flag set.
// - Reset clears the flag; writing one to it does nothing.
// - Interrupt enable bit 6 is read/write, reset to zero.
// - Center select clear and upper mode bit set give edge-aligned PWM.
// - Upper mode bit zero: code 00 capture, code 01 compare.
// - Edge/level field 00 releases the pin regardless of mode.
// - Capture trigger: 01 rising, 10 falling, 11 both edges.
// - Compare action: 00 none, 01 toggle, 10 low, 11 high.
// - Edge PWM: 10 clears pin on match, X1 sets it.
// - Center PWM: 10 clears on up match, X1 sets on up match.
// - Any write to the status register resets the value read latch.
// - Center select set forces center-aligned PWM on every channel.
module tcc_channel #(
    parameter int ADDR_W = 2
) (
    input wire logic i_clk, // Bus clock, 40 MHz.
    input wire logic i_nrst, // Synchronous reset, active low.
    input wire tcc_pkg::tcc_bus_s i_bus, // Register port request.
    output logic [7:0] o_rdata, // Read data, one cycle after the strobe.
    input wire tcc_pkg::tcc_tmr_s i_tmr, // Counter side signals.
    input wire logic i_pin, // Channel pin level.
    output logic o_pin_out, // Channel pin drive level.
    output logic o_pin_oe, // High while the channel drives the pin.
    output logic o_pin_release, // Pin handed to other control.
    output logic o_capture, // Pulse: latch counter into channel value.
    output logic o_coh_reset, // Pulse: reset channel value read latch.
    output tcc_pkg::tcc_mode_e o_mode, // Decoded channel mode.
    output logic o_ch_irq, // Channel interrupt request.
    output logic o_irq // Masked event status interrupt.
);
    import tcc_pkg::*;

    if (ADDR_W != 2) begin : g_chk
        $error("tcc_channel: ADDR_W must be 2");
    end

    logic flag_q;
    logic ie_q;
    logic ms_hi_q;
    logic ms_lo_q;
    logic [1:0] els_q;
    logic armed_q;
    logic pin_prev_q;
    logic pin_q;
    logic [7:0] rdata_q;
    logic [1:0] evt_q;
    logic [1:0] mask_q;
    logic capture_q;
    logic coh_q;
    tcc_mode_e mode;
    logic wr_csc;
    logic rd_csc;
    logic edge_hit;
    logic ch_event;
    logic flag_clear;
    logic [7:0] csc_view;

    assign wr_csc = i_bus.wr && (i_bus.addr == `TCC_OFS_CSC);
    assign rd_csc = i_bus.rd && (i_bus.addr == `TCC_OFS_CSC);

    // Center select overrides the per-channel mode bits.
    always_comb begin
        if (i_tmr.center_pwm_select) begin
            mode = TCC_MODE_CPWM;
        end else if (ms_hi_q) begin
            mode = TCC_MODE_EPWM;
        end else if (ms_lo_q) begin
            mode = TCC_MODE_COMPARE;
        end else begin
            mode = TCC_MODE_CAPTURE;
        end
    end

    // The pin is taken as synchronous, so one register gives the edge.
    always_comb begin
        unique case (els_q)
            `TCC_ELS_01: edge_hit = i_pin && !pin_prev_q;
            `TCC_ELS_10: edge_hit = !i_pin && pin_prev_q;
            `TCC_ELS_11: edge_hit = i_pin != pin_prev_q;
            default: edge_hit = 1'b0;
        endcase
    end

    always_comb begin
        unique case (mode)
            TCC_MODE_CAPTURE: ch_event = edge_hit;
            TCC_MODE_COMPARE: ch_event = i_tmr.cnt_match;
            default: ch_event = i_tmr.cnt_match && !i_tmr.duty_extreme;
        endcase
    end

    assign flag_clear = wr_csc && armed_q && !i_bus.wdata[`TCC_BIT_FLAG];

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= i_pin;
        end
    end

    // Event wins over a clear in the same cycle, so nothing is lost.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            flag_q <= 1'b0;
        end else if (ch_event) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    // The read half of the clear sequence; a new event disarms it again.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            armed_q <= 1'b0;
        end else if (ch_event || flag_clear) begin
            armed_q <= 1'b0;
        end else if (rd_csc && flag_q) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ie_q <= 1'b0;
            ms_hi_q <= 1'b0;
            ms_lo_q <= 1'b0;
            els_q <= `TCC_ELS_OFF;
        end else if (wr_csc) begin
            ie_q <= i_bus.wdata[`TCC_BIT_IE];
            ms_hi_q <= i_bus.wdata[`TCC_BIT_MS_HI];
            ms_lo_q <= i_bus.wdata[`TCC_BIT_MS_LO];
            els_q <= i_bus.wdata[`TCC_ELS_HI:`TCC_ELS_LO];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            coh_q <= 1'b0;
            capture_q <= 1'b0;
        end else begin
            coh_q <= wr_csc;
            capture_q <= (mode == TCC_MODE_CAPTURE) && edge_hit;
        end
    end

    // Pin action per mode; only edge PWM starts its periods on overflow.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pin_q <= 1'b0;
        end else begin
            unique case (mode)
                TCC_MODE_COMPARE: begin
                    if (i_tmr.cnt_match) begin
                        unique case (els_q)
                            `TCC_ELS_01: pin_q <= !pin_q;
                            `TCC_ELS_10: pin_q <= 1'b0;
                            `TCC_ELS_11: pin_q <= 1'b1;
                            default: pin_q <= pin_q;
                        endcase
                    end
                end
                TCC_MODE_EPWM: begin
                    if (els_q != `TCC_ELS_OFF) begin
                        if (i_tmr.cnt_match) begin
                            pin_q <= els_q[0];
                        end else if (i_tmr.cnt_ovf) begin
                            pin_q <= !els_q[0];
                        end
                    end
                end
                TCC_MODE_CPWM: begin
                    if (els_q != `TCC_ELS_OFF && i_tmr.cnt_match) begin
                        pin_q <= i_tmr.count_up ? els_q[0] : !els_q[0];
                    end
                end
                default: pin_q <= pin_q;
            endcase
        end
    end

    // Interrupt block: sticky bits, write one to clear, set wins.
    // A hit that lands while the flag is still pending gets its own bit, so software can tell it lagged.
    localparam logic [`TCC_EVT_W-1:0] EVT_RST = `TCC_RST_EVT;
    logic [`TCC_EVT_W-1:0] evt_src;
    logic wr_evt;

    assign evt_src[`TCC_EVT_SET] = ch_event;
    assign evt_src[`TCC_EVT_OVR] = ch_event && flag_q;
    assign wr_evt = i_bus.wr && (i_bus.addr == `TCC_OFS_EVT);

    for (genvar g = 0; g < `TCC_EVT_W; g++) begin : g_evt
        always_ff @(posedge i_clk) begin
            if (!i_nrst) begin
                evt_q[g] <= EVT_RST[g];
            end else if (evt_src[g]) begin
                evt_q[g] <= 1'b1;
            end else if (wr_evt && i_bus.wdata[g]) begin
                evt_q[g] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            mask_q <= `TCC_RST_EVT;
        end else if (i_bus.wr && i_bus.addr == `TCC_OFS_MASK) begin
            mask_q <= i_bus.wdata[1:0];
        end
    end

    assign csc_view = {flag_q, ie_q, ms_hi_q, ms_lo_q, els_q, 2'h0};

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_q <= `TCC_RST_BYTE;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                `TCC_OFS_CSC: rdata_q <= csc_view;
                `TCC_OFS_EVT: rdata_q <= {6'h00, evt_q};
                `TCC_OFS_MASK: rdata_q <= {6'h00, mask_q};
                default: rdata_q <= `TCC_RST_BYTE;
            endcase
        end else begin
            rdata_q <= `TCC_RST_BYTE;
        end
    end

    assign o_rdata = rdata_q;
    assign o_mode = mode;
    assign o_pin_release = (els_q == `TCC_ELS_OFF);
    // Capture never drives; released pin never driven.
    assign o_pin_oe = !o_pin_release && (mode != TCC_MODE_CAPTURE);
    assign o_pin_out = pin_q;
    assign o_capture = capture_q;
    assign o_coh_reset = coh_q;
    assign o_ch_irq = flag_q && ie_q;
    assign o_irq = |(evt_q & mask_q);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_armed_by_read;
        rd_csc && flag_q && !ch_event;
    endsequence

    sequence s_zero_write;
        wr_csc && !i_bus.wdata[`TCC_BIT_FLAG] && !ch_event;
    endsequence

    a_capture_sets_flag: assert property ((mode == TCC_MODE_CAPTURE) && edge_hit |=> flag_q && o_capture)
        else $error("capture edge did not set flag");
    a_match_sets_flag: assert property ((mode != TCC_MODE_CAPTURE) && i_tmr.cnt_match && !i_tmr.duty_extreme |=> flag_q)
        else $error("match did not set flag");
    a_extreme_no_flag: assert property (((mode == TCC_MODE_EPWM) || (mode == TCC_MODE_CPWM)) && !flag_q
        && i_tmr.duty_extreme |=> !flag_q)
        else $error("flag set at extreme duty");
    a_irq_follows_flag: assert property (ch_event && ie_q && !wr_csc |=> o_ch_irq)
        else $error("channel irq missing");
    a_clear_sequence: assert property (s_armed_by_read ##1 (!ch_event [*1]) ##0 s_zero_write |=> !flag_q)
        else $error("clear sequence did not clear flag");
    a_clear_needs_read: assert property ($fell(flag_q) |-> $past(armed_q))
        else $error("flag cleared without read");
    a_event_keeps_flag: assert property (ch_event |=> flag_q && !armed_q)
        else $error("event lost in clear");
    a_write_one_keeps: assert property (wr_csc && i_bus.wdata[`TCC_BIT_FLAG] && !ch_event |=> flag_q == $past(flag_q))
        else $error("writing one changed flag");
    a_release_pin: assert property (els_q == `TCC_ELS_OFF |-> o_pin_release && !o_pin_oe)
        else $error("released pin still driven");
    a_toggle_match: assert property (mode == TCC_MODE_COMPARE && els_q == `TCC_ELS_01 && i_tmr.cnt_match
        |=> pin_q != $past(pin_q))
        else $error("compare toggle missing");
    a_center_forced: assert property (i_tmr.center_pwm_select |-> mode == TCC_MODE_CPWM)
        else $error("center select not honoured");
    a_coh_pulse: assert property (wr_csc |=> o_coh_reset ##1 (o_coh_reset == $past(wr_csc)))
        else $error("coherency reset pulse wrong");

    // Mode writes only count when center select is still clear in the cycle after.
    sequence s_edge_pwm_write;
        wr_csc && i_bus.wdata[`TCC_BIT_MS_HI] ##1 !i_tmr.center_pwm_select;
    endsequence

    sequence s_plain_mode_write;
        wr_csc && !i_bus.wdata[`TCC_BIT_MS_HI] ##1 !i_tmr.center_pwm_select;
    endsequence

    sequence s_event_then_zero;
        ch_event ##1 (wr_csc && !i_bus.wdata[`TCC_BIT_FLAG]);
    endsequence

    a_irq_disabled: assert property (wr_csc && !i_bus.wdata[`TCC_BIT_IE] |=> !o_ch_irq)
        else $error("channel irq with enable clear");

    a_enable_written: assert property (wr_csc |=> ie_q == $past(i_bus.wdata[`TCC_BIT_IE]))
        else $error("interrupt enable not stored");

    a_csc_readback: assert property (rd_csc |=> o_rdata == $past(csc_view))
        else $error("status read data wrong");

    a_edge_pwm_mode: assert property (s_edge_pwm_write |-> mode == TCC_MODE_EPWM)
        else $error("upper mode bit did not give edge PWM");

    a_plain_mode: assert property (s_plain_mode_write
        |-> mode == ($past(i_bus.wdata[`TCC_BIT_MS_LO]) ? TCC_MODE_COMPARE : TCC_MODE_CAPTURE))
        else $error("lower mode bit decoded wrong");

    a_capture_no_drive: assert property (mode == TCC_MODE_CAPTURE |-> !o_pin_oe)
        else $error("capture channel drives pin");

    a_rise_only: assert property (mode == TCC_MODE_CAPTURE && els_q == `TCC_ELS_01
        && !i_pin && pin_prev_q |=> !o_capture)
        else $error("falling edge captured in rising mode");

    a_fall_capture: assert property (mode == TCC_MODE_CAPTURE && els_q == `TCC_ELS_10
        && !i_pin && pin_prev_q |=> o_capture)
        else $error("falling edge not captured");

    a_both_edges: assert property (mode == TCC_MODE_CAPTURE && els_q == `TCC_ELS_11
        && (i_pin != pin_prev_q) |=> o_capture)
        else $error("edge missed in both-edge mode");

    a_compare_low: assert property (mode == TCC_MODE_COMPARE && els_q == `TCC_ELS_10
        && i_tmr.cnt_match |=> !o_pin_out)
        else $error("compare clear action missing");

    a_compare_high: assert property (mode == TCC_MODE_COMPARE && els_q == `TCC_ELS_11
        && i_tmr.cnt_match |=> o_pin_out)
        else $error("compare set action missing");

    a_compare_hold: assert property (mode == TCC_MODE_COMPARE && els_q == `TCC_ELS_OFF
        |=> $stable(o_pin_out))
        else $error("compare moved a released pin");

    a_edge_pwm_match: assert property (mode == TCC_MODE_EPWM && els_q != `TCC_ELS_OFF
        && i_tmr.cnt_match |=> o_pin_out == $past(els_q[0]))
        else $error("edge PWM match level wrong");

    a_edge_pwm_start: assert property (mode == TCC_MODE_EPWM && els_q != `TCC_ELS_OFF
        && !i_tmr.cnt_match && i_tmr.cnt_ovf |=> o_pin_out != $past(els_q[0]))
        else $error("edge PWM period start level wrong");

    a_center_up_match: assert property (mode == TCC_MODE_CPWM && els_q != `TCC_ELS_OFF
        && i_tmr.cnt_match && i_tmr.count_up |=> o_pin_out == $past(els_q[0]))
        else $error("center PWM up match level wrong");

    a_event_then_zero: assert property (s_event_then_zero |=> flag_q)
        else $error("late event lost by clear");

    a_coh_idle: assert property (!wr_csc |=> !o_coh_reset)
        else $error("coherency reset without write");

    a_rdata_idle: assert property (!i_bus.rd |=> o_rdata == `TCC_RST_BYTE)
        else $error("read data stood too long");

    a_unmapped_read: assert property (i_bus.rd && (i_bus.addr != `TCC_OFS_CSC)
        && (i_bus.addr != `TCC_OFS_EVT) && (i_bus.addr != `TCC_OFS_MASK) |=> o_rdata == `TCC_RST_BYTE)
        else $error("unmapped read not zero");

    a_status_set: assert property (ch_event |=> evt_q[`TCC_EVT_SET])
        else $error("event status bit not set");

    a_status_late: assert property (ch_event && flag_q |=> evt_q[`TCC_EVT_OVR])
        else $error("late event status bit not set");

endmodule
`default_nettype wire

/* tcc_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
    input wire logic i_level, // Level the outside circuit drives.
    input wire logic i_dut_out, // Channel drive level.
    input wire logic i_dut_oe, // Channel drive enable.
    output logic o_pin // Resolved pin level.
);
    // The outside circuit yields while the channel drives, so the wire never carries a fight.
    assign o_pin = i_dut_oe ? i_dut_out : i_level;
endmodule
`default_nettype wire

/* timer_channel_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_channel_control_test;
    import tcc_pkg::*;
    logic i_clk, i_nrst, ext_level, pin, pin_out, pin_oe, pin_rel, capture, coh_rst, ch_irq, irq;
    tcc_bus_s bus;
    tcc_tmr_s tmr;
    tcc_mode_e mode;
    logic [7:0] rdata;
    logic [7:0] d;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    tcc_channel dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata), .i_tmr(tmr), .i_pin(pin),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_release(pin_rel), .o_capture(capture),
        .o_coh_reset(coh_rst), .o_mode(mode), .o_ch_irq(ch_irq), .o_irq(irq));
    tcc_pin_model pin_u (.i_level(ext_level), .i_dut_out(pin_out), .i_dut_oe(pin_oe), .o_pin(pin));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end
    // Inputs move 1 ns after the edge so no check races the design's own updates.
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask
    // Both strobes drop here; wr and rd each drop only the other strobe, so no task assigns one twice in a step.
    task automatic cyc();
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        tick();
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.rd <= 1'b0;
        bus.wr <= 1'b1;
        tick();
    endtask
    task automatic rd(input logic [1:0] a);
        bus.addr <= a;
        bus.wr <= 1'b0;
        bus.rd <= 1'b1;
        tick();
        d = rdata;
    endtask
    task automatic ev(input tcc_tmr_s t);
        tmr <= t;
        cyc();
        tmr.cnt_match <= 1'b0;
        tmr.cnt_ovf <= 1'b0;
    endtask
    function automatic logic [7:0] csc(input logic ie, input logic [1:0] ms, input logic [1:0] e);
        return {1'b0, ie, ms, e, 2'b00};
    endfunction
    function automatic tcc_mode_e exp_mode(input logic cp, input logic [1:0] ms);
        return cp ? TCC_MODE_CPWM : ms[1] ? TCC_MODE_EPWM : ms[0] ? TCC_MODE_COMPARE : TCC_MODE_CAPTURE;
    endfunction
    function automatic logic exp_cap(input logic p, input logic c, input logic [1:0] e);
        return (e[0] && !p && c) || (e[1] && p && !c);
    endfunction
    task automatic pwm(input logic [1:0] ms, input logic [1:0] e, input tcc_tmr_s t, input logic ep, input logic ef);
        wr(2'h0, csc(1'b0, ms, e));
        ev(t);
        chk(pin_out, ep);
        rd(2'h0);
        chk(d[7], ef);
        if (d[7]) wr(2'h0, d & 8'h7f);
    endtask
    initial begin
        logic [1:0] e;
        logic p, c, hit;
        tcc_mode_e em;
        logic [1:0] els_t[5] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2};
        logic pin_t[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        void'($urandom(7619));
        i_nrst = 1'b0;
        bus = '0;
        tmr = '0;
        ext_level = 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        i_nrst <= 1'b1;
        cyc();
        chk(pin_rel, 1'b1);
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0]);
            chk(d, 8'h00);
        end
        wr(2'h3, 8'hff);
        rd(2'h3);
        chk(d, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            e = 2'($urandom);
            em = exp_mode(i[3], i[2:1]);
            tmr.center_pwm_select <= i[3];
            wr(2'h0, csc(i[0], i[2:1], e));
            chk({6'h00, mode}, {6'h00, em});
            chk(pin_rel, e == 2'h0);
            chk(pin_oe, e != 2'h0 && em != TCC_MODE_CAPTURE);
            rd(2'h0);
            chk(d, csc(i[0], i[2:1], e));
        end
        tmr <= '0;
        $display("test mode done");
        for (int k = 1; k < 4; k++) begin
            wr(2'h0, 8'h00);
            ext_level <= 1'b0;
            cyc();
            cyc();
            wr(2'h0, csc(1'b0, 2'h0, k[1:0]));
            p = 1'b0;
            hit = 1'b0;
            repeat (12) begin
                c = 1'($urandom);
                ext_level <= c;
                cyc();
                chk(capture, exp_cap(p, c, k[1:0]));
                hit = hit | exp_cap(p, c, k[1:0]);
                p = c;
            end
            rd(2'h0);
            chk(d[7], hit);
            if (d[7]) wr(2'h0, d & 8'h7f);
            rd(2'h0);
            chk(d[7], 1'b0);
        end
        $display("test capture done");
        for (int k = 0; k < 5; k++) begin
            wr(2'h0, csc(1'b0, 2'h1, els_t[k]));
            ev('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
            chk(pin_out, pin_t[k]);
            rd(2'h0);
            chk(d[7], 1'b1);
            wr(2'h0, d & 8'h7f);
        end
        $display("test compare done");
        pwm(2'h2, 2'h2, '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, 1'b1, 1'b0);
        pwm(2'h2, 2'h2, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, 1'b1);
        pwm(2'h3, 2'h1, '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0}, 1'b1, 1'b0);
        pwm(2'h0, 2'h2, '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1}, 1'b0, 1'b1);
        pwm(2'h1, 2'h1, '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1}, 1'b1, 1'b0);
        tmr <= '0;
        $display("test pwm done");
        wr(2'h1, 8'h03);
        wr(2'h0, csc(1'b1, 2'h1, 2'h0));
        chk(coh_rst, 1'b1);
        ev('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
        chk(coh_rst, 1'b0);
        chk(ch_irq, 1'b1);
        wr(2'h0, csc(1'b0, 2'h1, 2'h0));
        chk(ch_irq, 1'b0);
        wr(2'h0, csc(1'b1, 2'h1, 2'h0) | 8'h80);
        rd(2'h0);
        chk(d[7], 1'b1);
        ev('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
        wr(2'h0, csc(1'b1, 2'h1, 2'h0));
        rd(2'h0);
        chk(d[7], 1'b1);
        wr(2'h0, csc(1'b1, 2'h1, 2'h0));
        chk(ch_irq, 1'b0);
        rd(2'h1);
        chk(d, 8'h03);
        wr(2'h2, 8'h02);
        chk(irq, 1'b1);
        wr(2'h2, 8'h00);
        chk(irq, 1'b0);
        wr(2'h1, 8'h03);
        rd(2'h1);
        chk(d, 8'h00);
        $display("test clear done");
        give_verdict();
    end
endmodule
`default_nettype wire
